//--- osd_cmd_pkg.sv
/*
  Shared constants and types for the display command decoder and RAM loader.
  Assumes a single clock domain and that command bytes arrive already assembled.
*/
package osd_cmd_pkg;
  localparam int ADDR_W = 8;
  localparam int ENTRY_W = 12;
  localparam logic [1:0] BANK_RST = 2'h0;
  localparam logic [1:0] BANK_0 = 2'h0;
  localparam logic [1:0] BANK_1 = 2'h1;
  localparam logic [1:0] BANK_2 = 2'h2;
  localparam logic [6:0] FONT_LAST = 7'h7c;
  localparam logic [6:0] CODE_CR = 7'h7e;
  localparam logic [6:0] CODE_SPACE = 7'h7f;
  localparam logic [5:0] PAT_BANK = 6'h1e;
  localparam logic [3:0] PAT_ADDR_HI = 4'h2;
  localparam logic [3:0] PAT_ADDR_LO = 4'h3;
  localparam logic [3:0] PAT_CTRL1 = 4'h4;
  localparam logic [3:0] PAT_CTRL2 = 4'h5;
  localparam logic [3:0] PAT_BLINK = 4'h6;
  localparam logic [3:0] PAT_PORTCFG = 4'h7;
  localparam logic [3:0] PAT_VPOS_HI = 4'h9;
  localparam logic [3:0] PAT_VH_MID = 4'ha;
  localparam logic [3:0] PAT_HPOS_LO = 4'hb;
  localparam logic [2:0] PAT_ATTR = 3'h0;
  localparam logic [1:0] PAT_DIV = 2'h0;
  localparam logic [1:0] PAT_PORTW = 2'h3;
  localparam logic [7:0] ADDR_RST = 8'h00;
  localparam logic [4:0] ATTR_RST = 5'h00;
  localparam logic [6:0] CHAR_RST = 7'h00;
  localparam logic [5:0] DIV_RST = 6'h00;
  localparam logic [3:0] CTRL1_RST = 4'h2;
  localparam logic [3:0] CTRL2_RST = 4'h0;
  localparam logic [3:0] BLINK_RST = 4'h0;

  typedef struct packed {
    logic [1:0] scan_sel;
    logic output_polarity_flag;
    logic display_clock_on;
  } ctrl1_t;

  typedef struct packed {
    logic line_sync_polarity;
    logic frame_sync_polarity;
    logic [1:0] display_style;
  } ctrl2_t;

  typedef struct packed {
    logic [1:0] blink_rate;
    logic [1:0] blink_duty;
  } blink_t;

  typedef struct packed {
    logic [5:0] vert_start;
    logic [5:0] horiz_start;
  } position_t;

  typedef struct packed {
    logic horiz_stabiliser_on;
    logic halftone_backdrop_on;
    logic [1:0] first_line_size;
  } ctrl3_t;

  typedef struct packed {
    logic is_font;
    logic is_cr;
    logic is_space;
    logic [3:0] colour;
    logic blink;
    logic [1:0] next_size;
    logic [1:0] line_gap;
    logic end_of_screen;
    logic marker_enable;
  } entry_info_t;
endpackage

//--- osd_command_decoder_ram_loader.sv
/*
  Command interpreter and display RAM loader of an on-screen-display device.
  Assumes command bytes arrive assembled with a one-cycle strobe, and that the
  raster logic reads the RAM through the read port and reports back-trace.
*/
`timescale 1ns/1ns
module osd_command_decoder_ram_loader #(
  parameter int DEPTH = 256,
  parameter bit SPACE_BACKDROP = 1'b0
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_byte,
  input wire logic [7:0] rd_addr,
  input wire logic back_trace,
  input wire logic pixel_on,
  output logic [11:0] rd_entry,
  output osd_cmd_pkg::entry_info_t rd_info,
  output logic [7:0] display_write_address,
  output logic [4:0] attribute_holding,
  output logic [6:0] character_holding,
  output logic [1:0] bank_sel,
  output logic [5:0] osc_divisor,
  output osd_cmd_pkg::ctrl1_t ctrl1,
  output osd_cmd_pkg::ctrl2_t ctrl2,
  output osd_cmd_pkg::blink_t blink_cfg,
  output osd_cmd_pkg::position_t start_pos,
  output logic port_mode_sel,
  output logic out_port_bit_zero,
  output logic out_port_bit_one,
  output logic out_port_bit_four,
  output logic [3:0] frame_colour,
  output osd_cmd_pkg::ctrl3_t ctrl3,
  output logic [3:0] colour_out,
  output logic overlay_blank_output,
  output logic recording_marker_output,
  output logic screen_done
);
  logic [11:0] ram [DEPTH];
  logic dec_bank, dec_attr, dec_char, dec_ahi, dec_alo, dec_div, dec_c1, dec_c2;
  logic dec_blink, dec_pcfg, dec_pw, dec_vhi, dec_vh, dec_hlo, dec_fcol, dec_c3;
  logic [11:0] entry_now;
  logic [3:0] backdrop;
  logic marker_on;
  logic bank0, bank1, bank2;
  logic any_hit;

  assign bank0 = bank_sel == osd_cmd_pkg::BANK_0;
  assign bank1 = bank_sel == osd_cmd_pkg::BANK_1;
  assign bank2 = bank_sel == osd_cmd_pkg::BANK_2;

  // Byte decode; every command is qualified by the strobe.
  always_comb begin
    dec_bank = cmd_valid && cmd_byte[7:2] == osd_cmd_pkg::PAT_BANK;
    dec_attr = cmd_valid && !bank_sel[0] && cmd_byte[7:5] == osd_cmd_pkg::PAT_ATTR;
    dec_char = cmd_valid && bank2 && cmd_byte[7];
    dec_ahi = cmd_valid && bank0 && cmd_byte[7:4] == osd_cmd_pkg::PAT_ADDR_HI;
    dec_alo = cmd_valid && bank0 && cmd_byte[7:4] == osd_cmd_pkg::PAT_ADDR_LO;
    dec_fcol = cmd_valid && bank0 && cmd_byte[7:4] == osd_cmd_pkg::PAT_CTRL1;
    dec_c3 = cmd_valid && bank0 && cmd_byte[7:4] == osd_cmd_pkg::PAT_CTRL2;
    dec_div = cmd_valid && bank1 && cmd_byte[7:6] == osd_cmd_pkg::PAT_DIV;
    dec_c1 = cmd_valid && bank1 && cmd_byte[7:4] == osd_cmd_pkg::PAT_CTRL1;
    dec_c2 = cmd_valid && bank1 && cmd_byte[7:4] == osd_cmd_pkg::PAT_CTRL2;
    dec_blink = cmd_valid && bank1 && cmd_byte[7:4] == osd_cmd_pkg::PAT_BLINK;
    dec_pcfg = cmd_valid && bank1 && cmd_byte[7:4] == osd_cmd_pkg::PAT_PORTCFG
               && !cmd_byte[3] && cmd_byte[1:0] == 2'h0;
    dec_pw = cmd_valid && bank1 && cmd_byte[7:6] == osd_cmd_pkg::PAT_PORTW;
    dec_vhi = cmd_valid && bank1 && cmd_byte[7:4] == osd_cmd_pkg::PAT_VPOS_HI;
    dec_vh = cmd_valid && bank1 && cmd_byte[7:4] == osd_cmd_pkg::PAT_VH_MID;
    dec_hlo = cmd_valid && bank1 && cmd_byte[7:4] == osd_cmd_pkg::PAT_HPOS_LO;
    // The bank pattern needs bit 3 set and port config bit 3 clear, so they never overlap; bank wins.
    if (dec_bank) begin
      dec_pcfg = 1'b0;
    end
  end

  assign any_hit = dec_bank | dec_attr | dec_char | dec_ahi | dec_alo | dec_div | dec_c1 | dec_c2
                   | dec_blink | dec_pcfg | dec_pw | dec_vhi | dec_vh | dec_hlo | dec_fcol | dec_c3;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bank_sel <= osd_cmd_pkg::BANK_RST;
    end else if (dec_bank) begin
      bank_sel <= cmd_byte[1:0];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      display_write_address <= osd_cmd_pkg::ADDR_RST;
    end else if (dec_ahi) begin
      display_write_address[7:4] <= cmd_byte[3:0];
    end else if (dec_alo) begin
      display_write_address[3:0] <= cmd_byte[3:0];
    end else if (dec_char) begin
      display_write_address <= display_write_address + 8'h01;
    end
  end

  // Only the attribute command touches this register.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      attribute_holding <= osd_cmd_pkg::ATTR_RST;
    end else if (dec_attr) begin
      attribute_holding <= cmd_byte[4:0];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      character_holding <= osd_cmd_pkg::CHAR_RST;
    end else if (dec_char) begin
      character_holding <= cmd_byte[6:0];
    end
  end

  // The new code goes straight to RAM with the current attribute.
  always_ff @(posedge clk) begin
    if (dec_char) begin
      ram[display_write_address] <= {cmd_byte[6:0], attribute_holding};
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      osc_divisor <= osd_cmd_pkg::DIV_RST;
      ctrl1 <= osd_cmd_pkg::CTRL1_RST;
      ctrl2 <= osd_cmd_pkg::CTRL2_RST;
      blink_cfg <= osd_cmd_pkg::BLINK_RST;
      start_pos <= '0;
      frame_colour <= 4'h0;
      ctrl3 <= '0;
    end else begin
      if (dec_div) osc_divisor <= cmd_byte[5:0];
      if (dec_c1) ctrl1 <= cmd_byte[3:0];
      if (dec_c2) ctrl2 <= cmd_byte[3:0];
      if (dec_blink) blink_cfg <= cmd_byte[3:0];
      if (dec_vhi) start_pos.vert_start[5:2] <= cmd_byte[3:0];
      if (dec_vh) begin
        start_pos.vert_start[1:0] <= cmd_byte[3:2];
        start_pos.horiz_start[5:4] <= cmd_byte[1:0];
      end
      if (dec_hlo) start_pos.horiz_start[3:0] <= cmd_byte[3:0];
      if (dec_fcol) frame_colour <= cmd_byte[3:0];
      if (dec_c3) ctrl3 <= cmd_byte[3:0];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      port_mode_sel <= 1'b0;
      out_port_bit_zero <= 1'b0;
      out_port_bit_one <= 1'b0;
      out_port_bit_four <= 1'b0;
    end else begin
      if (dec_pcfg) port_mode_sel <= cmd_byte[2];
      if (dec_pw) begin
        out_port_bit_zero <= cmd_byte[0];
        out_port_bit_one <= cmd_byte[1];
        out_port_bit_four <= cmd_byte[4];
      end
    end
  end

  // Read port for the raster logic, registered.
  always_ff @(posedge clk) begin
    entry_now <= ram[rd_addr];
  end
  assign rd_entry = entry_now;

  always_comb begin
    rd_info = '0;
    rd_info.is_font = entry_now[11:5] <= osd_cmd_pkg::FONT_LAST;
    rd_info.is_cr = entry_now[11:5] == osd_cmd_pkg::CODE_CR;
    rd_info.is_space = entry_now[11:5] == osd_cmd_pkg::CODE_SPACE;
    rd_info.colour = entry_now[4:1];
    rd_info.blink = rd_info.is_font && entry_now[0];
    rd_info.next_size = entry_now[4:3];
    rd_info.line_gap = entry_now[2:1];
    rd_info.end_of_screen = rd_info.is_cr && entry_now[0];
    rd_info.marker_enable = entry_now[0];
  end

  // Space entries latch background and marker for following characters.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      backdrop <= 4'h0;
      marker_on <= 1'b0;
      screen_done <= 1'b0;
    end else begin
      if (rd_info.is_space) begin
        backdrop <= entry_now[4:1];
        marker_on <= entry_now[0];
      end
      if (back_trace) screen_done <= 1'b0;
      if (rd_info.end_of_screen) screen_done <= 1'b1;
    end
  end

  // Outputs; carriage return is transparent, space transparent unless option.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      colour_out <= 4'h0;
      overlay_blank_output <= 1'b0;
      recording_marker_output <= 1'b0;
    end else if (back_trace || screen_done) begin
      colour_out <= 4'h0;
      overlay_blank_output <= 1'b0;
      recording_marker_output <= 1'b0;
    end else if (rd_info.is_font) begin
      colour_out <= pixel_on ? entry_now[4:1] : backdrop;
      overlay_blank_output <= 1'b1;
      recording_marker_output <= marker_on;
    end else if (rd_info.is_space && SPACE_BACKDROP) begin
      colour_out <= entry_now[4:1];
      overlay_blank_output <= 1'b1;
      recording_marker_output <= entry_now[0];
    end else begin
      colour_out <= 4'h0;
      overlay_blank_output <= 1'b0;
      recording_marker_output <= 1'b0;
    end
  end

  addr_step_a: assert property (@(posedge clk) disable iff (!arst_n)
    dec_char && !dec_ahi |=> display_write_address == $past(display_write_address) + 8'h01)
    else $error("Write address did not step after a character.");
  ram_write_a: assert property (@(posedge clk) disable iff (!arst_n)
    dec_char |=> ram[$past(display_write_address)] == {$past(cmd_byte[6:0]), $past(attribute_holding)})
    else $error("RAM entry does not match holding data.");
  attr_keep_a: assert property (@(posedge clk) disable iff (!arst_n)
    !dec_attr |=> $stable(attribute_holding))
    else $error("Attribute changed without its command.");
  bank_load_a: assert property (@(posedge clk) disable iff (!arst_n)
    dec_bank |=> bank_sel == $past(cmd_byte[1:0]))
    else $error("Bank select not loaded.");
  addr_hi_a: assert property (@(posedge clk) disable iff (!arst_n)
    cmd_valid && bank0 && cmd_byte[7:4] == 4'h2 |=> display_write_address[7:4] == $past(cmd_byte[3:0]))
    else $error("High nibble not loaded.");
  trace_quiet_a: assert property (@(posedge clk) disable iff (!arst_n)
    back_trace |=> colour_out == 4'h0 && !overlay_blank_output && !recording_marker_output)
    else $error("Outputs active during back-trace.");
  ignore_a: assert property (@(posedge clk) disable iff (!arst_n)
    !any_hit |=> $stable(display_write_address) && $stable(character_holding) && $stable(bank_sel))
    else $error("Unmatched byte changed state.");
  char_bank_a: assert property (@(posedge clk) disable iff (!arst_n)
    cmd_valid && cmd_byte[7] && !bank2 |=> $stable(character_holding))
    else $error("Character accepted outside its bank.");
  div_load_a: assert property (@(posedge clk) disable iff (!arst_n)
    dec_div |=> osc_divisor == $past(cmd_byte[5:0]))
    else $error("Divisor not loaded.");
  addr_lo_a: assert property (@(posedge clk) disable iff (!arst_n)
    dec_alo |=> display_write_address[3:0] == $past(cmd_byte[3:0]))
    else $error("Low nibble not loaded.");
  attr_load_a: assert property (@(posedge clk) disable iff (!arst_n)
    dec_attr |=> attribute_holding == $past(cmd_byte[4:0]))
    else $error("Attribute not loaded.");
  char_load_a: assert property (@(posedge clk) disable iff (!arst_n)
    dec_char |=> character_holding == $past(cmd_byte[6:0]))
    else $error("Character code not loaded.");
  ctrl_one_a: assert property (@(posedge clk) disable iff (!arst_n)
    dec_c1 |=> ctrl1 == $past(cmd_byte[3:0]))
    else $error("First control register not loaded.");
  ctrl_two_a: assert property (@(posedge clk) disable iff (!arst_n)
    dec_c2 |=> ctrl2 == $past(cmd_byte[3:0]))
    else $error("Second control register not loaded.");
  blink_load_a: assert property (@(posedge clk) disable iff (!arst_n)
    dec_blink |=> blink_cfg == $past(cmd_byte[3:0]))
    else $error("Blink setting not loaded.");
  vpos_high_a: assert property (@(posedge clk) disable iff (!arst_n)
    dec_vhi |=> start_pos.vert_start[5:2] == $past(cmd_byte[3:0]))
    else $error("Vertical start high bits not loaded.");
  pos_mid_a: assert property (@(posedge clk) disable iff (!arst_n)
    dec_vh |=> {start_pos.vert_start[1:0], start_pos.horiz_start[5:4]} == $past(cmd_byte[3:0]))
    else $error("Middle start position bits not loaded.");
  hpos_low_a: assert property (@(posedge clk) disable iff (!arst_n)
    dec_hlo |=> start_pos.horiz_start[3:0] == $past(cmd_byte[3:0]))
    else $error("Horizontal start low bits not loaded.");
  port_cfg_a: assert property (@(posedge clk) disable iff (!arst_n)
    dec_pcfg |=> port_mode_sel == $past(cmd_byte[2]))
    else $error("Port configuration not loaded.");
  port_write_a: assert property (@(posedge clk) disable iff (!arst_n)
    dec_pw |=> {out_port_bit_four, out_port_bit_one, out_port_bit_zero} == {$past(cmd_byte[4]), $past(cmd_byte[1:0])})
    else $error("Port bits not written.");
  frame_colour_a: assert property (@(posedge clk) disable iff (!arst_n)
    dec_fcol |=> frame_colour == $past(cmd_byte[3:0]))
    else $error("Frame colour not loaded.");
  ctrl_three_a: assert property (@(posedge clk) disable iff (!arst_n)
    dec_c3 |=> ctrl3 == $past(cmd_byte[3:0]))
    else $error("Third control register not loaded.");
  bank_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
    !dec_bank |=> $stable(bank_sel))
    else $error("Bank changed without its command.");

  // Read side: entry kinds steer the registered display outputs.
  cr_clear_a: assert property (@(posedge clk) disable iff (!arst_n)
    rd_info.is_cr |=> !overlay_blank_output && colour_out == 4'h0)
    else $error("Carriage return cell not transparent.");
  space_clear_a: assert property (@(posedge clk) disable iff (!arst_n)
    rd_info.is_space && !SPACE_BACKDROP |=> !overlay_blank_output)
    else $error("Space cell not transparent.");
  space_latch_a: assert property (@(posedge clk) disable iff (!arst_n)
    rd_info.is_space |=> backdrop == $past(rd_entry[4:1]) && marker_on == $past(rd_entry[0]))
    else $error("Space entry settings not latched.");
  marker_follow_a: assert property (@(posedge clk) disable iff (!arst_n)
    !back_trace && !screen_done && rd_info.is_font |=> recording_marker_output == $past(marker_on))
    else $error("Marker output does not follow the space setting.");
  screen_end_a: assert property (@(posedge clk) disable iff (!arst_n)
    rd_info.end_of_screen |=> screen_done)
    else $error("End of screen not flagged.");
  done_quiet_a: assert property (@(posedge clk) disable iff (!arst_n)
    screen_done |=> !overlay_blank_output && !recording_marker_output)
    else $error("Outputs active after end of screen.");

  char_c: cover property (@(posedge clk) disable iff (!arst_n) dec_char ##1 dec_char);
  bank_c: cover property (@(posedge clk) disable iff (!arst_n) dec_bank ##1 dec_attr);
  eos_c: cover property (@(posedge clk) disable iff (!arst_n) rd_info.end_of_screen);
  font_out_c: cover property (@(posedge clk) disable iff (!arst_n) overlay_blank_output && recording_marker_output);
  trace_end_c: cover property (@(posedge clk) disable iff (!arst_n) back_trace ##1 !back_trace);
endmodule

//--- host_cmd_model.sv
/*
  Behavioural model of the host that feeds assembled command bytes to the decoder.
  Assumes the caller enters send_seq one time unit after a rising clock edge.
*/
`timescale 1ns/1ns
module host_cmd_model (
  input wire logic clk,
  output logic cmd_valid,
  output logic [7:0] cmd_byte
);
  initial begin
    cmd_valid = 1'b0;
    cmd_byte = 8'h55;
  end

  // Bytes go out whole, one per cycle, back to back.
  task automatic send_seq(input logic [7:0] q[$]);
    foreach (q[i]) begin
      cmd_byte = q[i];
      cmd_valid = 1'b1;
      @(posedge clk);
      #1;
    end
    // The byte lines show the inverted last byte once the strobe is released.
    cmd_valid = 1'b0;
    cmd_byte = ~cmd_byte;
    // One idle edge keeps a following call from raising the strobe in this step.
    @(posedge clk);
    #1;
  endtask
endmodule

//--- osd_command_decoder_ram_loader_bench.sv
/*
  Self-checking bench for the command decoder and display RAM loader.
  Assumes the host model drives commands and the bench drives the raster inputs.
*/
`timescale 1ns/1ns
module osd_command_decoder_ram_loader_bench;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic cmd_valid;
  logic [7:0] cmd_byte;
  logic [7:0] rd_addr = 8'h00;
  logic back_trace = 1'b0;
  logic pixel_on = 1'b0;
  int bad_count = 0;
  int compares = 0;

  always #10 clk = ~clk;

  host_cmd_model host (.clk(clk), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte));

  osd_command_decoder_ram_loader dut (
    .clk(clk), .arst_n(arst_n), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte),
    .rd_addr(rd_addr), .back_trace(back_trace), .pixel_on(pixel_on),
    .rd_entry(), .rd_info(), .display_write_address(), .attribute_holding(),
    .character_holding(), .bank_sel(), .osc_divisor(), .ctrl1(), .ctrl2(),
    .blink_cfg(), .start_pos(), .port_mode_sel(), .out_port_bit_zero(),
    .out_port_bit_one(), .out_port_bit_four(), .frame_colour(), .ctrl3(),
    .colour_out(), .overlay_blank_output(), .recording_marker_output(), .screen_done()
  );

  task automatic chk(input string nm, input logic [11:0] exp, input logic [11:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // The entry appears one cycle after its address is presented.
  task automatic read_at(input logic [7:0] a);
    rd_addr = a;
    @(posedge clk);
    #1;
  endtask

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    #200000;
    bad_count++;
    $display("watchdog expired");
    wrap_up();
  end

  initial begin
    repeat (2) @(posedge clk);
    #1;
    arst_n = 1'b1;
    chk("bank", 12'h000, 12'(dut.bank_sel));
    chk("addr", 12'h000, 12'(dut.display_write_address));
    chk("attr", 12'h000, 12'(dut.attribute_holding));
    chk("ctrl1", 12'h002, 12'(dut.ctrl1));
    $display("test reset done");

    host.send_seq('{8'h78, 8'h23, 8'h35, 8'h0a, 8'h7a, 8'h81, 8'h23, 8'h82});
    chk("addr", 12'h037, 12'(dut.display_write_address));
    chk("char", 12'h002, 12'(dut.character_holding));
    chk("attr", 12'h00a, 12'(dut.attribute_holding));
    read_at(8'h35);
    chk("ram35", 12'h02a, dut.rd_entry);
    read_at(8'h36);
    chk("ram36", 12'h04a, dut.rd_entry);
    $display("test load done");

    host.send_seq('{8'h1b, 8'hfe, 8'h13, 8'hff, 8'h0b, 8'h90});
    read_at(8'h37);
    chk("cr entry", 12'hfdb, dut.rd_entry);
    chk("cr kind", 12'h002, 12'({dut.rd_info.is_font, dut.rd_info.is_cr, dut.rd_info.is_space}));
    chk("cr size", 12'h003, 12'(dut.rd_info.next_size));
    chk("cr gap", 12'h001, 12'(dut.rd_info.line_gap));
    chk("cr end", 12'h001, 12'(dut.rd_info.end_of_screen));
    read_at(8'h38);
    chk("sp kind", 12'h001, 12'({dut.rd_info.is_font, dut.rd_info.is_cr, dut.rd_info.is_space}));
    chk("sp colour", 12'h009, 12'(dut.rd_info.colour));
    chk("sp marker", 12'h001, 12'(dut.rd_info.marker_enable));
    read_at(8'h39);
    chk("ft kind", 12'h004, 12'({dut.rd_info.is_font, dut.rd_info.is_cr, dut.rd_info.is_space}));
    chk("ft colour", 12'h005, 12'(dut.rd_info.colour));
    chk("ft blink", 12'h001, 12'(dut.rd_info.blink));
    $display("test codes done");

    host.send_seq('{8'h79, 8'h05, 8'h2a, 8'h4b, 8'h5c, 8'h69, 8'h9d, 8'ha6, 8'hb7, 8'h74, 8'hd3});
    chk("bank", 12'h001, 12'(dut.bank_sel));
    chk("divisor", 12'h02a, 12'(dut.osc_divisor));
    chk("ctrl1", 12'h00b, 12'(dut.ctrl1));
    chk("ctrl2", 12'h00c, 12'(dut.ctrl2));
    chk("blink", 12'h009, 12'(dut.blink_cfg));
    chk("position", {6'h35, 6'h27}, 12'(dut.start_pos));
    chk("port mode", 12'h001, 12'(dut.port_mode_sel));
    chk("ports", 12'h007, 12'({dut.out_port_bit_four, dut.out_port_bit_one, dut.out_port_bit_zero}));
    chk("attr", 12'h00b, 12'(dut.attribute_holding));
    $display("test bank one done");

    host.send_seq('{8'h78, 8'h47, 8'h5d, 8'h82});
    chk("frame colour", 12'h007, 12'(dut.frame_colour));
    chk("ctrl3", 12'h00d, 12'(dut.ctrl3));
    chk("char", 12'h010, 12'(dut.character_holding));
    chk("addr", 12'h03a, 12'(dut.display_write_address));
    $display("test bank zero done");

    pixel_on = 1'b1;
    back_trace = 1'b1;
    rd_addr = 8'h39;
    @(posedge clk);
    #1;
    back_trace = 1'b0;
    @(posedge clk);
    #1;
    chk("font colour", 12'h005, 12'(dut.colour_out));
    chk("font blank", 12'h001, 12'(dut.overlay_blank_output));
    chk("font marker", 12'h001, 12'(dut.recording_marker_output));
    pixel_on = 1'b0;
    @(posedge clk);
    #1;
    chk("backdrop", 12'h009, 12'(dut.colour_out));
    back_trace = 1'b1;
    @(posedge clk);
    #1;
    chk("colour", 12'h000, 12'(dut.colour_out));
    chk("blank", 12'h000, 12'(dut.overlay_blank_output));
    chk("marker", 12'h000, 12'(dut.recording_marker_output));
    $display("test back trace done");
    wrap_up();
  end
endmodule
